// >>> core/cxm_pkg.sv
// package for the transceiver mode and fail-safe controller
// assumes a 10 mhz system clock and pin levels from the analog front end

package cxm_pkg;

   // ----------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 100;
   localparam int WAKE_FILTER_NS    = 1000;
   localparam int TX_DOM_TIMEOUT_NS = 1000000;
   localparam int BUS_DOM_TIMEOUT_NS = 1000000;
   // least times, rounded up to whole cycles
   localparam int WAKE_FILTER_CYC   = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TX_DOM_TIMEOUT_CYC =
      (TX_DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUS_DOM_TIMEOUT_CYC =
      (BUS_DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------
   // fifo sizing
   // ----------------------------------------------------------
   localparam int TXQ_DEPTH = 32;
   localparam int TXQ_WIDTH = 1;

   // ----------------------------------------------------------
   // pin group and reset levels
   // ----------------------------------------------------------
   typedef struct packed {
      logic tx_recessive;
      logic mode_select_in;
      logic bus_dominant;
      logic lp_bus_dominant;
      logic main_supply_ok;
      logic io_supply_ok;
      logic over_temp;
   } cxm_pins_s;

   // pulled-up inputs read high, supplies read absent
   localparam cxm_pins_s PINS_RST = '{
      tx_recessive: 1'b1, mode_select_in: 1'b1, bus_dominant: 1'b0,
      lp_bus_dominant: 1'b0, main_supply_ok: 1'b0, io_supply_ok: 1'b0,
      over_temp: 1'b0};

   typedef enum logic [1:0] {
      CXM_OFF,
      CXM_STANDBY,
      CXM_NORMAL
   } cxm_mode_e;

   typedef struct packed {
      logic tx_drive_dominant;
      logic bus_bias_ground;
      logic split_bias_oe;
      logic bus_engaged;
      logic normal_mode;
   } cxm_drv_s;

   localparam cxm_drv_s DRV_RST = '0;

endpackage

// >>> core/cxm_transceiver.sv
// mode control, wake filter and fail-safe logic of a can transceiver
// assumes analog front end delivers bus state and supply/thermal flags as levels

`timescale 1ns/100ps

// ----------------------------------------------------------
// transmit queue
// ----------------------------------------------------------
module cxm_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push_w = in_valid && in_ready;
   wire              pop_w  = out_valid && out_ready;

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem[rd_ptr_r];

   always_ff @(posedge clk) begin
      if (push_w) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         wr_ptr_r <= push_w ? wr_ptr_r + 1'b1 : wr_ptr_r;
         rd_ptr_r <= pop_w ? rd_ptr_r + 1'b1 : rd_ptr_r;
         count_r  <= count_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
      end
   end
endmodule // cxm_fifo

// ----------------------------------------------------------
// transceiver control
// ----------------------------------------------------------
module cxm_transceiver
   import cxm_pkg::*;
#(
   parameter int WAKE_CYC   = cxm_pkg::WAKE_FILTER_CYC,
   parameter int TX_TO_CYC  = cxm_pkg::TX_DOM_TIMEOUT_CYC,
   parameter int BUS_TO_CYC = cxm_pkg::BUS_DOM_TIMEOUT_CYC
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire cxm_pkg::cxm_pins_s pins_in,
   output logic                   rx_data_out,
   output cxm_pkg::cxm_drv_s      drv_out,
   output logic                   tx_timeout_out,
   output logic                   thermal_off_out
);
   import cxm_pkg::*;

   localparam int CW = 32;

   function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
      return (v == '1) ? v : v + 1'b1;
   endfunction

   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   cxm_pins_s meta_r;
   cxm_pins_s pins_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= PINS_RST;
         pins_r <= PINS_RST;
      end else begin
         meta_r <= pins_in;
         pins_r <= meta_r;
      end
   end

   // ----------------------------------------------------------
   // mode selection
   // ----------------------------------------------------------
   cxm_mode_e mode_r;
   cxm_mode_e mode_nxt;

   assign mode_nxt = !pins_r.io_supply_ok   ? CXM_OFF :
                     !pins_r.main_supply_ok ? CXM_STANDBY :
                     pins_r.mode_select_in  ? CXM_STANDBY :
                                              CXM_NORMAL;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_r <= CXM_OFF;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   wire normal_w  = (mode_r == CXM_NORMAL);
   wire standby_w = (mode_r == CXM_STANDBY);

   // ----------------------------------------------------------
   // transmit dominant time-out
   // ----------------------------------------------------------
   logic [CW-1:0] tx_cnt_r;
   logic          tx_to_r;
   wire           tx_to_hit_w = (tx_cnt_r >= CW'(TX_TO_CYC));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_cnt_r <= '0;
         tx_to_r  <= 1'b0;
      end else begin
         tx_cnt_r <= pins_r.tx_recessive ? '0 : sat_inc(tx_cnt_r);
         tx_to_r  <= !pins_r.tx_recessive && (tx_to_r || tx_to_hit_w);
      end
   end

   // ----------------------------------------------------------
   // overtemperature latch
   // ----------------------------------------------------------
   logic ot_r;
   wire  ot_nxt = pins_r.over_temp || (ot_r && !pins_r.tx_recessive);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ot_r <= 1'b0;
      end else begin
         ot_r <= ot_nxt;
      end
   end

   // ----------------------------------------------------------
   // transmit queue
   // ----------------------------------------------------------
   wire drv_en_w = normal_w && !tx_to_r && !ot_r;
   wire q_in_ready;
   wire q_out_valid;
   wire q_out_dom;

   // queue always drained, so no stale samples replay after a cut
   cxm_fifo #(
      .WIDTH (TXQ_WIDTH),
      .DEPTH (TXQ_DEPTH)
   ) cxm_fifo_i (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (normal_w),
      .in_ready  (q_in_ready),
      .in_data   (!pins_r.tx_recessive),
      .out_valid (q_out_valid),
      .out_ready (1'b1),
      .out_data  (q_out_dom)
   );

   wire tx_dom_w = drv_en_w && q_out_valid && q_out_dom && !pins_r.tx_recessive;

   // ----------------------------------------------------------
   // wake filter and bus time-out
   // ----------------------------------------------------------
   logic [CW-1:0] wf_cnt_r;
   logic          wf_state_r;
   logic          lp_prev_r;
   logic [CW-1:0] bus_cnt_r;
   logic          bus_to_r;
   wire           lp_w       = pins_r.lp_bus_dominant;
   wire           wf_diff_w  = (lp_w != wf_state_r);
   wire           wf_pass_w  = wf_diff_w && (wf_cnt_r >= CW'(WAKE_CYC));
   wire           bus_rise_w = lp_w && !lp_prev_r;
   wire           bus_hit_w  = (bus_cnt_r >= CW'(BUS_TO_CYC));
   wire           bus_hold_w = bus_to_r && wf_state_r; // cancel kept until filter is recessive or the bus turns dominant again

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wf_cnt_r   <= '0;
         wf_state_r <= 1'b0;
         lp_prev_r  <= 1'b0;
      end else begin
         wf_cnt_r   <= (wf_diff_w && !wf_pass_w) ? sat_inc(wf_cnt_r) : '0;
         wf_state_r <= wf_pass_w ? lp_w : wf_state_r;
         lp_prev_r  <= lp_w;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_cnt_r <= '0;
         bus_to_r  <= 1'b0;
      end else begin
         bus_cnt_r <= (!lp_w || bus_rise_w) ? '0 : sat_inc(bus_cnt_r);
         bus_to_r  <= !bus_rise_w && ((lp_w && bus_hit_w) || bus_hold_w);
      end
   end

   // ----------------------------------------------------------
   // receive output and drivers
   // ----------------------------------------------------------
   wire rx_nxt = normal_w  ? !pins_r.bus_dominant :
                 standby_w ? !(wf_state_r && !bus_to_r) :
                             1'b1;
   cxm_drv_s drv_nxt;

   assign drv_nxt.tx_drive_dominant = tx_dom_w;
   assign drv_nxt.bus_bias_ground   = standby_w;
   assign drv_nxt.split_bias_oe     = normal_w;
   assign drv_nxt.bus_engaged       = (mode_r != CXM_OFF);
   assign drv_nxt.normal_mode       = normal_w;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_data_out     <= 1'b1;
         drv_out         <= DRV_RST;
         tx_timeout_out  <= 1'b0;
         thermal_off_out <= 1'b0;
      end else begin
         rx_data_out     <= rx_nxt;
         drv_out         <= drv_nxt;
         tx_timeout_out  <= tx_to_r;
         thermal_off_out <= ot_r;
      end
   end

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   normal_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
      pins_r.io_supply_ok && pins_r.main_supply_ok && !pins_r.mode_select_in
      |=> mode_r == CXM_NORMAL) else $error("normal mode not entered");

   normal_rx_a: assert property (@(posedge clk) disable iff (!reset_n)
      normal_w |=> rx_data_out == !$past(pins_r.bus_dominant))
      else $error("receive output not following bus");

   standby_tx_a: assert property (@(posedge clk) disable iff (!reset_n)
      standby_w |=> !drv_out.tx_drive_dominant) else $error("transmit in standby");

   wake_filter_a: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(wf_state_r) |-> $past(wf_cnt_r) >= CW'(WAKE_CYC))
      else $error("wake state changed too early");

   wake_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
      standby_w && pins_r.mode_select_in && pins_r.io_supply_ok |=> !normal_w)
      else $error("wake changed mode");

   bias_ground_a: assert property (@(posedge clk) disable iff (!reset_n)
      standby_w |=> drv_out.bus_bias_ground && !drv_out.split_bias_oe)
      else $error("standby bias wrong");

   tx_timeout_a: assert property (@(posedge clk) disable iff (!reset_n)
      tx_to_r |-> !tx_dom_w) else $error("transmitter active after time-out");

   tx_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      pins_r.tx_recessive |=> tx_cnt_r == '0 && !tx_to_r) else $error("timer not cleared");

   bus_timeout_a: assert property (@(posedge clk) disable iff (!reset_n)
      standby_w && bus_to_r ##1 standby_w |-> rx_data_out)
      else $error("wake not cancelled");

   undervolt_a: assert property (@(posedge clk) disable iff (!reset_n)
      pins_r.io_supply_ok && !pins_r.main_supply_ok |=> standby_w)
      else $error("main undervoltage not in standby");

   io_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !pins_r.io_supply_ok |=> ##1 !drv_out.bus_engaged && !drv_out.tx_drive_dominant)
      else $error("engaged without io supply");

   thermal_a: assert property (@(posedge clk) disable iff (!reset_n)
      ot_r && !pins_r.tx_recessive |=> ot_r) else $error("thermal release while dominant");

   thermal_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
      ot_r |-> !tx_dom_w)
      else $error("transmitter active while hot");

   standby_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
      pins_r.io_supply_ok && pins_r.mode_select_in |=> standby_w)
      else $error("standby not entered");

   wake_rx_a: assert property (@(posedge clk) disable iff (!reset_n)
      standby_w && wf_state_r && !bus_to_r |=> !rx_data_out)
      else $error("wake request not shown");

   io_monitor_a: assert property (@(posedge clk) disable iff (!reset_n)
      standby_w && !pins_r.main_supply_ok && wf_state_r && !bus_to_r |=> !rx_data_out)
      else $error("wake lost without main supply");

   bus_start_a: assert property (@(posedge clk) disable iff (!reset_n)
      bus_rise_w |=> bus_cnt_r == '0 && !bus_to_r)
      else $error("bus timer not restarted");

   bus_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      !pins_r.lp_bus_dominant |=> bus_cnt_r == '0)
      else $error("bus timer not cleared");

   split_float_a: assert property (@(posedge clk) disable iff (!reset_n)
      !normal_w |=> !drv_out.split_bias_oe)
      else $error("split driven outside normal");

   cover_wake_c: cover property (@(posedge clk) disable iff (!reset_n)
      standby_w && !rx_data_out);
   cover_txto_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(tx_to_r));
   cover_busto_c: cover property (@(posedge clk) disable iff (!reset_n)
      standby_w && $rose(bus_to_r));
   cover_txq_c: cover property (@(posedge clk) disable iff (!reset_n)
      q_in_ready && q_out_valid && q_out_dom);

endmodule // cxm_transceiver

// >>> dv/cxm_bus_model.sv
// bus model: wired dominance of this node and of other nodes
// assumes drv_out of the transceiver and a dominance request from the bench

`timescale 1ns/100ps

module cxm_bus_model
   import cxm_pkg::*;
#(
   parameter int LAT = 1
) (
   input  wire logic              clk,
   input  wire cxm_pkg::cxm_drv_s drv,
   input  wire logic              other_dom,
   output logic                   bus_dominant,
   output logic                   lp_bus_dominant
);
   // ----------------------------------------------------------
   // line state, seen after LAT cycles (1 to 4)
   // ----------------------------------------------------------
   logic [3:0] dly_r;
   wire        line_dom = (drv.tx_drive_dominant & drv.bus_engaged) | other_dom;

   always_ff @(posedge clk) begin
      dly_r <= {dly_r[2:0], line_dom};
   end

   assign bus_dominant    = dly_r[LAT-1];
   assign lp_bus_dominant = dly_r[LAT-1];
endmodule // cxm_bus_model

// >>> dv/can_transceiver_mode_failsafe_bench.sv
// bench for the transceiver mode and fail-safe controller
// assumes cxm_pkg, cxm_transceiver and the bus model are compiled first

`timescale 1ns/100ps

module can_transceiver_mode_failsafe_bench;
   import cxm_pkg::*;
   logic      clk;
   logic      reset_n;
   cxm_pins_s pins;
   logic      other_dom;
   logic      bus_dom;
   logic      lp_dom;
   cxm_pins_s pins_all;
   logic      rx_data_out;
   cxm_drv_s  drv_out;
   logic      tx_timeout_out;
   logic      thermal_off_out;
   int        n_fail;
   int        samples_checked;

   assign pins_all = {pins.tx_recessive, pins.mode_select_in, bus_dom, lp_dom,
                      pins.main_supply_ok, pins.io_supply_ok, pins.over_temp};

   // ----------------------------------------------------------
   // design and bus
   // ----------------------------------------------------------
   cxm_transceiver #(.WAKE_CYC(3), .TX_TO_CYC(40), .BUS_TO_CYC(40)) cxm_transceiver_i (
      .clk(clk), .reset_n(reset_n), .pins_in(pins_all), .rx_data_out(rx_data_out),
      .drv_out(drv_out), .tx_timeout_out(tx_timeout_out), .thermal_off_out(thermal_off_out));

   cxm_bus_model #(.LAT(2)) cxm_bus_model_i (
      .clk(clk), .drv(drv_out), .other_dom(other_dom), .bus_dominant(bus_dom),
      .lp_bus_dominant(lp_dom));

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic chk(input string what, input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic results();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_reset();
      chk("rx idle", rx_data_out, 1'b1);
      chk("drivers off", drv_out === DRV_RST, 1'b1);
   endtask

   task automatic t_normal();
      pins.io_supply_ok = 1'b1;
      pins.main_supply_ok = 1'b1;
      pins.mode_select_in = 1'b0;
      tick(8);
      chk("normal mode", drv_out.normal_mode, 1'b1);
      chk("split on", drv_out.split_bias_oe, 1'b1);
      chk("bias ground", drv_out.bus_bias_ground, 1'b0);
      chk("rx recessive", rx_data_out, 1'b1);
      other_dom = 1'b1;
      tick(6);
      chk("rx dominant", rx_data_out, 1'b0);
      other_dom = 1'b0;
      tick(6);
      chk("rx back", rx_data_out, 1'b1);
   endtask

   task automatic t_tx_timeout();
      for (int i = 0; i < 8; i++) begin
         pins.tx_recessive = i[0];
         tick(8);
      end
      chk("no timeout short bits", tx_timeout_out, 1'b0);
      pins.tx_recessive = 1'b0;
      tick(10);
      chk("tx drive", drv_out.tx_drive_dominant, 1'b1);
      chk("rx loop", rx_data_out, 1'b0);
      tick(22);
      chk("no early timeout", tx_timeout_out, 1'b0);
      tick(30);
      chk("timeout set", tx_timeout_out, 1'b1);
      chk("drive off", drv_out.tx_drive_dominant, 1'b0);
      chk("bus released", rx_data_out, 1'b1);
      pins.tx_recessive = 1'b1;
      tick(6);
      chk("timeout clear", tx_timeout_out, 1'b0);
      pins.tx_recessive = 1'b0;
      tick(6);
      chk("drive again", drv_out.tx_drive_dominant, 1'b1);
      pins.tx_recessive = 1'b1;
      tick(6);
   endtask

   task automatic t_standby();
      pins.mode_select_in = 1'b1;
      tick(8);
      chk("standby", drv_out.normal_mode, 1'b0);
      chk("bias ground", drv_out.bus_bias_ground, 1'b1);
      chk("split float", drv_out.split_bias_oe, 1'b0);
      pins.tx_recessive = 1'b0;
      tick(8);
      chk("tx ignored", drv_out.tx_drive_dominant, 1'b0);
      pins.tx_recessive = 1'b1;
      tick(4);
   endtask

   task automatic t_wake();
      other_dom = 1'b1;
      tick(2);
      other_dom = 1'b0;
      tick(10);
      chk("glitch filtered", rx_data_out, 1'b1);
      other_dom = 1'b1;
      tick(14);
      chk("wake request", rx_data_out, 1'b0);
      chk("stays standby", drv_out.normal_mode, 1'b0);
      tick(50);
      chk("bus timeout", rx_data_out, 1'b1);
      other_dom = 1'b0;
      tick(7);
      chk("no wake", rx_data_out, 1'b1);
      tick(3);
      other_dom = 1'b1;
      tick(30);
      other_dom = 1'b0;
      tick(10);
      other_dom = 1'b1;
      tick(30);
      chk("timer restarted", rx_data_out, 1'b0);
      other_dom = 1'b0;
      tick(10);
   endtask

   task automatic t_supply();
      pins.mode_select_in = 1'b0;
      tick(8);
      pins.main_supply_ok = 1'b0;
      tick(8);
      chk("forced standby", drv_out.normal_mode, 1'b0);
      chk("split off", drv_out.split_bias_oe, 1'b0);
      other_dom = 1'b1;
      tick(14);
      chk("wake on io only", rx_data_out, 1'b0);
      other_dom = 1'b0;
      tick(10);
      pins.main_supply_ok = 1'b1;
      tick(8);
      chk("normal again", drv_out.normal_mode, 1'b1);
      pins.io_supply_ok = 1'b0;
      tick(8);
      chk("zero load", drv_out.bus_engaged, 1'b0);
      chk("all off", drv_out === DRV_RST, 1'b1);
      pins.io_supply_ok = 1'b1;
      tick(8);
      chk("io back", drv_out.normal_mode, 1'b1);
   endtask

   task automatic t_thermal();
      pins.tx_recessive = 1'b0;
      tick(4);
      pins.over_temp = 1'b1;
      tick(6);
      chk("thermal off", thermal_off_out, 1'b1);
      chk("drive cut", drv_out.tx_drive_dominant, 1'b0);
      pins.over_temp = 1'b0;
      tick(6);
      chk("held while tx low", thermal_off_out, 1'b1);
      pins.tx_recessive = 1'b1;
      tick(6);
      chk("thermal release", thermal_off_out, 1'b0);
      pins.tx_recessive = 1'b0;
      tick(6);
      chk("drive restored", drv_out.tx_drive_dominant, 1'b1);
      pins.tx_recessive = 1'b1;
      tick(4);
   endtask

   // ----------------------------------------------------------
   // clock, reset, sequence and watchdog
   // ----------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      n_fail = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      pins = PINS_RST;
      other_dom = 1'b0;
      tick(16);
      reset_n = 1'b1;
      tick(4);
      t_reset();
      t_normal();
      t_tx_timeout();
      t_standby();
      t_wake();
      t_supply();
      t_thermal();
      results();
   end

   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule // can_transceiver_mode_failsafe_bench
